// ### core/vpc_capture.v
// Summary of operation
// RULE_01: eight-bit chrominance input bus accepted
// RULE_02: eight-bit luminance input bus accepted
// RULE_03: source drives line sync on dedicated input
// RULE_04: pixel clock samples data and line sync
// RULE_05: pixel clock at most 16 MHz
// RULE_06: latch 16-bit pixel each rising pixel edge; the code latches only at pixel edges with line sync high
// RULE_07: source drives frame sync on dedicated input
// RULE_08: store only in active line; counters restart
`timescale 1ns/1ps
`default_nettype none
`include "vpc_map.vh"
module vpc_capture #(
    parameter COL_W = `VPC_COL_W,
    parameter ROW_W = `VPC_ROW_W
) (
    input wire CLK_I,
    input wire RST_B_I,
    input wire [`VPC_CHROMA_W-1:0] CHROMA_DATA_I,
    input wire [`VPC_LUMA_W-1:0] LUMA_DATA_I,
    input wire LINE_SYNC_IN_I,
    input wire FRAME_SYNC_IN_I,
    input wire PIXEL_CLK_I,
    input wire [COL_W-1:0] RD_ADDR_I,
    output wire [`VPC_PIXEL_W-1:0] RD_DATA_O,
    output reg [`VPC_PIXEL_W-1:0] PIXEL_O,
    output reg PIXEL_VALID_O,
    output reg [COL_W-1:0] COL_O,
    output reg [ROW_W-1:0] ROW_O,
    output reg LINE_DONE_O,
    output reg FRAME_START_O
);
    // three-stage synchronisers; stage one is read only by stage two
    reg [2:0] clk_sync;
    reg [2:0] line_sync_in_sync;
    reg [2:0] vs_sync;
    reg [`VPC_PIXEL_W-1:0] data_s1;
    reg [`VPC_PIXEL_W-1:0] data_s2;
    reg [`VPC_PIXEL_W-1:0] data_s3;
    // the data bus crosses as a whole: it is read only at a pixel edge, after
    // it has stood still for several system cycles, so no bit can be torn
    reg clk_level;
    reg vs_level;
    // line tracker and counters, with their next values
    reg [1:0] line_state;
    reg [1:0] next_line_state;
    reg [COL_W-1:0] col;
    reg [COL_W-1:0] next_col;
    reg [ROW_W-1:0] row;
    reg [ROW_W-1:0] next_row;
    reg line_seen;
    reg next_line_seen;
    wire next_clk_level;
    wire next_vs_level;
    wire clk_rise;
    wire vs_rise;
    wire line_active;
    wire line_sync_in_now;
    wire line_sync_in_fall;
    wire store;

    // line tracker states: blanking between lines, or inside an active line
    localparam LS_BLANK = 2'b00;
    localparam LS_ACTIVE = 2'b01;

    // filtered level: change counts once stages two and three agree
    function filt;
        input cur;
        input s2;
        input s3;
        begin
            filt = (s2 == s3) ? s2 : cur;
        end
    endfunction

    // column step; the one is sized so nothing is padded silently
    function [COL_W-1:0] col_inc;
        input [COL_W-1:0] c;
        begin
            col_inc = c + {{(COL_W-1){1'b0}}, 1'b1};
        end
    endfunction

    // row step, sized the same way as the column step
    function [ROW_W-1:0] row_inc;
        input [ROW_W-1:0] r;
        begin
            row_inc = r + {{(ROW_W-1){1'b0}}, 1'b1};
        end
    endfunction

    // data and line sync travel with the pixel clock through matched stages [RULE_04]
    always @(posedge CLK_I) begin
        clk_sync <= {clk_sync[1:0], PIXEL_CLK_I};
        line_sync_in_sync <= {line_sync_in_sync[1:0], LINE_SYNC_IN_I}; // [RULE_03]
        vs_sync <= {vs_sync[1:0], FRAME_SYNC_IN_I}; // [RULE_07]
        data_s1 <= {LUMA_DATA_I, CHROMA_DATA_I}; // [RULE_01] [RULE_02]
        data_s2 <= data_s1;
        data_s3 <= data_s2;
    end

    // pixel clock edge, found in the filtered clock; needs the pixel clock at
    // or below the limit so each half period spans several system cycles [RULE_05]
    assign next_clk_level = filt(clk_level, clk_sync[1], clk_sync[2]);
    assign clk_rise = next_clk_level & ~clk_level;
    // frame sync counts on its filtered rising edge only [RULE_07]
    assign next_vs_level = filt(vs_level, vs_sync[1], vs_sync[2]);
    assign vs_rise = next_vs_level & ~vs_level;
    // line sync read beside the data word taken at the same pixel edge [RULE_04]
    assign line_active = (line_state == LS_ACTIVE);
    assign line_sync_in_now = filt(line_active, line_sync_in_sync[1], line_sync_in_sync[2]);
    // store a pixel only when line sync is high at its own pixel edge [RULE_08]
    assign store = clk_rise & line_sync_in_now;
    assign line_sync_in_fall = clk_rise & ~line_sync_in_now & line_active;

    // filtered levels of the pixel clock and the frame sync
    always @(posedge CLK_I) begin
        if (!RST_B_I) begin
            clk_level <= 1'b0;
            vs_level <= 1'b0;
        end else begin
            clk_level <= next_clk_level;
            vs_level <= next_vs_level;
        end
    end

    // next values of the line tracker and the column and row counters
    always @* begin
        next_line_state = line_state;
        next_col = col;
        next_row = row;
        next_line_seen = line_seen;
        case (line_state)
            LS_BLANK: begin
                // a pixel edge with line sync high opens the line
                if (clk_rise && line_sync_in_now) begin
                    next_line_state = LS_ACTIVE;
                end
            end
            LS_ACTIVE: begin
                // the first pixel edge with line sync low closes it
                if (line_sync_in_fall) begin
                    next_line_state = LS_BLANK;
                end
            end
            default: begin
                // unused code; fall back to blanking rather than hang
                next_line_state = LS_BLANK;
            end
        endcase
        if (store) begin
            next_col = col_inc(col); // [RULE_08]
            next_line_seen = 1'b1;
        end
        // frame sync restarts rows; it wins over a line end [RULE_08]
        if (vs_rise) begin
            next_row = `VPC_COUNT_RST;
            next_col = `VPC_COUNT_RST;
            next_line_seen = 1'b0;
        end else if (line_sync_in_fall) begin
            // a line cut by frame sync before any pixel does not advance the row
            next_col = `VPC_COUNT_RST; // [RULE_08]
            next_line_seen = 1'b0;
            if (line_seen) begin
                next_row = row_inc(row);
            end
        end
    end

    // line tracker and counter registers
    always @(posedge CLK_I) begin
        if (!RST_B_I) begin
            line_state <= LS_BLANK;
            col <= `VPC_COUNT_RST;
            row <= `VPC_COUNT_RST;
            line_seen <= 1'b0;
        end else begin
            line_state <= next_line_state;
            col <= next_col;
            row <= next_row;
            line_seen <= next_line_seen;
        end
    end

    // pixel latch: word, column and row move together with the valid pulse
    always @(posedge CLK_I) begin
        if (!RST_B_I) begin
            PIXEL_O <= 16'h0000;
            PIXEL_VALID_O <= 1'b0;
            COL_O <= `VPC_COUNT_RST;
            ROW_O <= `VPC_COUNT_RST;
        end else begin
            PIXEL_VALID_O <= store; // [RULE_06]
            if (store) begin
                PIXEL_O <= data_s3; // [RULE_06]
                COL_O <= col;
                ROW_O <= row;
            end
        end
    end

    // line end and frame start pulses, one system cycle each
    always @(posedge CLK_I) begin
        if (!RST_B_I) begin
            LINE_DONE_O <= 1'b0;
            FRAME_START_O <= 1'b0;
        end else begin
            LINE_DONE_O <= line_sync_in_fall; // [RULE_08]
            FRAME_START_O <= vs_rise; // [RULE_07]
        end
    end

    // columns past the store depth wrap and overwrite the start of the line
    // line store, written only while the line is active [RULE_08]
    vpc_line_mem #(
        .DATA_W(`VPC_PIXEL_W),
        .ADDR_W(COL_W)
    ) u_mem (
        .CLK_I(CLK_I),
        .wr_en_i(store),
        .wr_addr_i(col),
        .wr_data_i(data_s3),
        .rd_addr_i(RD_ADDR_I),
        .rd_data_o(RD_DATA_O)
    );
endmodule // vpc_capture
`default_nettype wire

// ### core/vpc_map.vh
`ifndef VPC_MAP_VH
`define VPC_MAP_VH
// data widths
`define VPC_CHROMA_W 8
`define VPC_LUMA_W 8
`define VPC_PIXEL_W 16
// field positions inside the stored pixel word
`define VPC_LUMA_MSB 15
`define VPC_LUMA_LSB 8
`define VPC_CHROMA_MSB 7
`define VPC_CHROMA_LSB 0
// counter widths and reset values
`define VPC_COL_W 11
`define VPC_ROW_W 11
`define VPC_COUNT_RST 11'h000
// timing: fastest pixel clock in kHz, system clock in kHz
`define VPC_PCLK_MAX_KHZ 16000
`define VPC_SYS_KHZ 100000
// least system cycles per pixel-clock period (rounded down, at least one)
`define VPC_PCLK_MIN_CYC (`VPC_SYS_KHZ / `VPC_PCLK_MAX_KHZ)
`endif

// ### core/vpc_line_mem.v
`timescale 1ns/1ps
`default_nettype none
`include "vpc_map.vh"
// one-line pixel store, registered read port
module vpc_line_mem #(
    parameter DATA_W = 16,
    parameter ADDR_W = 11
) (
    input wire CLK_I,
    input wire wr_en_i,
    input wire [ADDR_W-1:0] wr_addr_i,
    input wire [DATA_W-1:0] wr_data_i,
    input wire [ADDR_W-1:0] rd_addr_i,
    output reg [DATA_W-1:0] rd_data_o
);
    reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    // write and registered read; a same-address read returns the old word
    always @(posedge CLK_I) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule // vpc_line_mem
`default_nettype wire

// ### testbench/vpc_props.sv
`timescale 1ns/1ps
`default_nettype none
module vpc_props #(
    parameter int COL_W = 11,
    parameter int ROW_W = 11
) (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic LINE_SYNC_IN_I,
    input wire logic [15:0] PIXEL_O,
    input wire logic PIXEL_VALID_O,
    input wire logic [COL_W-1:0] COL_O,
    input wire logic [ROW_W-1:0] ROW_O,
    input wire logic LINE_DONE_O,
    input wire logic FRAME_START_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    logic [5:0] lc = 6'h3f;
    wire v = PIXEL_VALID_O;
    wire d = LINE_DONE_O;
    wire f = FRAME_START_O;
    // cycles since line sync fell, held at top so it never wraps
    always @(posedge CLK_I) lc <= LINE_SYNC_IN_I ? 6'h00 : lc + {5'h00, lc != 6'h3f};
    sequence s_one(x); x ##1 !x; endsequence
    a_vld_one: assert property (v |-> s_one(v)) else $error("long valid");
    a_pix_hold: assert property ($changed(PIXEL_O) |-> v) else $error("pixel moved");
    a_line_gate: assert property (lc > 6'h10 |-> !v) else $error("stored off line");
    a_col_step: assert property ($changed(COL_O) |->
        COL_O == 0 || COL_O == $past(COL_O) + 1'b1) else $error("column jump");
    a_row_step: assert property ($changed(ROW_O) |->
        ROW_O == 0 || ROW_O == $past(ROW_O) + 1'b1) else $error("row jump");
    a_done_one: assert property (d |-> s_one(d)) else $error("long done");
    a_frm_one: assert property (f |-> s_one(f)) else $error("long frame");
    a_done_late: assert property (d |-> lc != 0 && lc < 6'h1e) else $error("done time");
    a_frm_idle: assert property (f |-> !v) else $error("pixel at frame");
endmodule // vpc_props
bind vpc_capture vpc_props #(.COL_W(COL_W), .ROW_W(ROW_W)) i_props (
    .CLK_I(CLK_I),
    .RST_B_I(RST_B_I),
    .LINE_SYNC_IN_I(LINE_SYNC_IN_I),
    .PIXEL_O(PIXEL_O),
    .PIXEL_VALID_O(PIXEL_VALID_O),
    .COL_O(COL_O),
    .ROW_O(ROW_O),
    .LINE_DONE_O(LINE_DONE_O),
    .FRAME_START_O(FRAME_START_O)
);
`default_nettype wire

// ### testbench/vpc_src.sv
`timescale 1ns/1ps
`default_nettype none
module vpc_src (
    input wire logic go_i,
    input wire logic [3:0] npix_i,
    output logic pclk_o = 1'b0,
    output logic [7:0] luma_o = 8'h00,
    output logic [7:0] chroma_o = 8'hff,
    output logic line_sync_o = 1'b0,
    output logic frame_sync_o = 1'b0
);
    integer r, e;
    // one 125 ns pixel period; inputs move on the low phase
    task pe(input [7:0] y, input l);
        begin
            luma_o = y;
            chroma_o = ~y;
            line_sync_o = l;
            #62.5 pclk_o = 1'b1;
            #62.5 pclk_o = 1'b0;
        end
    endtask
    // three lines a frame; line sync is high exactly on the pixels to keep,
    // and the clock stands still between frames
    always @(posedge go_i) begin
        frame_sync_o = 1'b1;
        repeat (3) pe(8'h5a, 1'b0);
        frame_sync_o = 1'b0;
        for (r = 0; r < 3; r = r + 1) begin
            pe(8'he7, 1'b0);
            for (e = 0; e < npix_i; e = e + 1)
                pe({r[3:0], e[3:0]}, 1'b1);
            repeat (3) pe(8'h3c, 1'b0);
        end
    end
endmodule // vpc_src
`default_nettype wire

// ### testbench/tb_vpc_capture.sv
`timescale 1ns/1ps
`default_nettype none
module tb_vpc_capture;
    logic CLK_I = 1'b0, RST_B_I = 1'b0, go = 1'b0;
    logic [3:0] np = 4'h4;
    logic [10:0] RD_ADDR_I = 11'h000;
    wire PIXEL_CLK_I, LINE_SYNC_IN_I, FRAME_SYNC_IN_I, PIXEL_VALID_O, LINE_DONE_O, FRAME_START_O;
    wire [7:0] CHROMA_DATA_I, LUMA_DATA_I;
    wire [15:0] RD_DATA_O, PIXEL_O;
    wire [10:0] COL_O, ROW_O;
    integer errors = 0, tests_run = 0, k = 0, nl = 0, nf = 0, cyc = 0;
    always #5 CLK_I = ~CLK_I;
    vpc_src i_src (
        .go_i(go),
        .npix_i(np),
        .pclk_o(PIXEL_CLK_I),
        .luma_o(LUMA_DATA_I),
        .chroma_o(CHROMA_DATA_I),
        .line_sync_o(LINE_SYNC_IN_I),
        .frame_sync_o(FRAME_SYNC_IN_I)
    );
    vpc_capture i_dut (
        .CLK_I(CLK_I),
        .RST_B_I(RST_B_I),
        .CHROMA_DATA_I(CHROMA_DATA_I),
        .LUMA_DATA_I(LUMA_DATA_I),
        .LINE_SYNC_IN_I(LINE_SYNC_IN_I),
        .FRAME_SYNC_IN_I(FRAME_SYNC_IN_I),
        .PIXEL_CLK_I(PIXEL_CLK_I),
        .RD_ADDR_I(RD_ADDR_I),
        .RD_DATA_O(RD_DATA_O),
        .PIXEL_O(PIXEL_O),
        .PIXEL_VALID_O(PIXEL_VALID_O),
        .COL_O(COL_O),
        .ROW_O(ROW_O),
        .LINE_DONE_O(LINE_DONE_O),
        .FRAME_START_O(FRAME_START_O)
    );
    task chk(input [15:0] a, b);
        begin
            tests_run = tests_run + 1;
            if (a !== b) begin
                errors = errors + 1;
                $display("[ERR] %0t %h %h", $time, a, b);
            end
        end
    endtask
    task complete_run;
        begin
            $display("tests %0d errors %0d", tests_run, errors);
            if (errors == 0 && tests_run > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    // stored pixels must carry the row and column the source sent
    always @(negedge CLK_I) begin
        cyc = cyc + 1;
        nl = nl + LINE_DONE_O;
        nf = nf + FRAME_START_O;
        if (PIXEL_VALID_O === 1'b1) begin
            chk(PIXEL_O, {4'(k / np), 4'(k % np), ~4'(k / np), ~4'(k % np)});
            chk(COL_O, k % np);
            chk(ROW_O, k / np);
            k = k + 1;
        end
        if (cyc == 6000) begin
            errors = errors + 1;
            complete_run;
        end
    end
    task run_frame(input [3:0] n);
        logic [7:0] lu;
        begin
            np = n;
            k = 0;
            nl = 0;
            nf = 0;
            go = 1'b1;
            @(negedge CLK_I) go = 1'b0;
            while (nl < 3) @(negedge CLK_I);
            repeat (40) @(negedge CLK_I);
            chk(k, 3 * n);
            chk(nl, 3);
            chk(nf, 1);
            lu = {4'h2, n - 4'h1};
            RD_ADDR_I = 11'(n - 4'h1);
            repeat (2) @(negedge CLK_I);
            chk(RD_DATA_O, {lu, ~lu});
        end
    endtask
    // reset between frames, with the source idle, clears the pixel, column and row outputs and leaves no false pixel behind
    task reset_mid;
        begin
            RST_B_I = 1'b0;
            repeat (2) @(negedge CLK_I);
            chk(PIXEL_O, 16'h0000);
            chk(COL_O, 16'h0000);
            chk(ROW_O, 16'h0000);
            repeat (4) @(negedge CLK_I);
            RST_B_I = 1'b1;
            k = 0;
            repeat (8) @(negedge CLK_I);
            chk(k, 0);
            chk(PIXEL_O, 16'h0000);
        end
    endtask
    initial begin
        repeat (16) @(negedge CLK_I);
        RST_B_I = 1'b1;
        run_frame(4'h4);
        run_frame(4'h1);
        run_frame(4'h8);
        reset_mid;
        run_frame(4'h2);
        complete_run;
    end
endmodule // tb_vpc_capture
`default_nettype wire
